// [bmf_fifo.sv]
// Bus-matching FIFO core with reset-latched configuration and status pins
//
// Overview of operation
// - Byte order pin low at master reset means big-endian, high little.
// - Wide write takes 18 data bits; narrow write takes only low nine.
// - Empty pin shows empty in standard mode, output valid in fall-through.
// - Full pin shows full in standard mode, space left in fall-through.
// - Two select pins plus load pick one of eight preset offsets.
// - Fall-through pin picks timing at master reset, then is serial input.
// - Half-full output shows whether stored count exceeds half capacity.
// - Parity pin low selects non-interspersed, high selects interspersed.
// - Parity setting only shapes parallel offset writes, never FIFO data.
// - Write width pin at master reset: low means x18, high means x9.
// - Load pin at master reset chooses serial or parallel offset loading.
// - After master reset, load steers accesses to the offset registers.
// - Master reset zeroes both pointers and the output register.
// - Master reset latches every configuration choice.
// - Output enable decides whether data outputs drive or float.
// - Read width pin at master reset: low means x18, high means x9.
// - Partial reset clears pointers and output, keeps modes and offsets.
`timescale 1ns/1ns
`include "bmf_params.svh"

module bmf_fifo (
  // Clock and system reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Reset pins, asynchronous to clock_i
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  // Configuration straps, sampled during master reset
  input wire logic byte_order_select_i,
  input wire logic fall_through_mode_select_i,
  input wire logic default_offset_sel0_i,
  input wire logic default_offset_sel1_i,
  input wire logic parity_placement_select_i,
  input wire logic write_width_select_i,
  input wire logic read_width_select_i,
  input wire logic flag_mode_select_i,
  input wire logic retransmit_mode_select_i,
  // Write side
  input wire logic write_en_n_i,
  input wire logic serial_en_n_i,
  input wire logic offset_load_n_i,
  input wire logic [17:0] write_data_inputs_i,
  // Read side
  input wire logic read_en_n_i,
  input wire logic output_enable_n_i,
  output logic [17:0] read_data_outputs_o,
  output logic read_data_oe_n_o,
  // Status pins, all active low
  output logic empty_flag_n_o,
  output logic full_flag_n_o,
  output logic half_full_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o
);

  bmf_pkg::bmf_state_t s;
  bmf_pkg::bmf_state_t next_s;

  logic [8:0] mem [0:1023];

  logic clr_data;
  logic [10:0] in_bytes;
  logic [10:0] out_bytes;
  logic [10:0] space;
  logic [10:0] wr_n;
  logic [10:0] rd_n;
  logic wr_ok;
  logic rd_take;
  logic ofs_wr;
  logic ofs_rd;
  logic mem_we0;
  logic mem_we1;
  logic [8:0] mem_d0;
  logic [8:0] mem_d1;
  logic [9:0] wptr1;
  logic [9:0] rptr1;
  logic [8:0] b0;
  logic [8:0] b1;
  logic [9:0] pofs;
  logic [9:0] dofs;

  always_comb begin
    next_s = s;
    // Pin resets: three stages, change taken once stages two and three agree
    next_s.mrs_sync = {s.mrs_sync[1:0], master_reset_n_i};
    next_s.prs_sync = {s.prs_sync[1:0], partial_reset_n_i};
    if (s.mrs_sync[1] == s.mrs_sync[2]) begin
      next_s.mrs_act = ~s.mrs_sync[2];
    end
    if (s.prs_sync[1] == s.prs_sync[2]) begin
      next_s.prs_act = ~s.prs_sync[2];
    end
    next_s.sw_prs = reg_we_i && (reg_addr_i == `BMF_REG_CTRL) &&
                    reg_wdata_i[`BMF_CTRL_PRS];
    clr_data = s.mrs_act | s.prs_act | s.sw_prs;
    next_s.oe_n = output_enable_n_i;

    in_bytes = s.cfg.narrow_wr ? `BMF_ONE_B : `BMF_TWO_B;
    out_bytes = s.cfg.narrow_rd ? `BMF_ONE_B : `BMF_TWO_B;
    space = `BMF_DEPTH - s.count;
    wptr1 = s.wptr + `BMF_PTR_ONE;
    rptr1 = s.rptr + `BMF_PTR_ONE;
    b0 = mem[s.rptr];
    b1 = mem[rptr1];

    // Load pin steers accesses away from storage once reset is over
    ofs_wr = !clr_data && !offset_load_n_i && !write_en_n_i;
    ofs_rd = !clr_data && !offset_load_n_i && !read_en_n_i;
    wr_ok = !clr_data && offset_load_n_i && !write_en_n_i &&
            (space >= in_bytes);
    if (s.cfg.fall_through_mode_select) begin
      rd_take = !clr_data && offset_load_n_i && (s.count >= out_bytes) &&
                (!s.ovalid || !read_en_n_i);
    end else begin
      rd_take = !clr_data && offset_load_n_i && !read_en_n_i &&
                (s.count >= out_bytes);
    end

    // Byte lane order into storage
    mem_we0 = wr_ok;
    mem_we1 = wr_ok && !s.cfg.narrow_wr;
    if (s.cfg.narrow_wr) begin
      mem_d0 = write_data_inputs_i[8:0];
      mem_d1 = write_data_inputs_i[8:0];
    end else if (s.cfg.little) begin
      mem_d0 = write_data_inputs_i[8:0];
      mem_d1 = write_data_inputs_i[17:9];
    end else begin
      mem_d0 = write_data_inputs_i[17:9];
      mem_d1 = write_data_inputs_i[8:0];
    end

    wr_n = wr_ok ? in_bytes : 11'h000;
    rd_n = rd_take ? out_bytes : 11'h000;
    if (wr_ok) begin
      next_s.wptr = s.cfg.narrow_wr ? wptr1 : s.wptr + `BMF_PTR_TWO;
    end
    if (rd_take) begin
      next_s.rptr = s.cfg.narrow_rd ? rptr1 : s.rptr + `BMF_PTR_TWO;
      if (s.cfg.narrow_rd) begin
        next_s.dout = {9'h000, b0};
      end else if (s.cfg.little) begin
        next_s.dout = {b1, b0};
      end else begin
        next_s.dout = {b0, b1};
      end
    end
    next_s.count = s.count + wr_n - rd_n;
    if (s.cfg.fall_through_mode_select) begin
      if (rd_take) begin
        next_s.ovalid = 1'b1;
      end else if (!read_en_n_i) begin
        next_s.ovalid = 1'b0;
      end
    end

    // Parallel offset value; parity lane skipped only when interspersed
    if (s.cfg.narrow_wr) begin
      pofs = {1'b0, write_data_inputs_i[8:0]};
    end else if (s.cfg.par_int) begin
      pofs = {write_data_inputs_i[10:9], write_data_inputs_i[7:0]};
    end else begin
      pofs = write_data_inputs_i[9:0];
    end
    if (ofs_wr && !s.cfg.serial) begin
      if (s.ofs_wsel) begin
        next_s.ofs_f = pofs;
      end else begin
        next_s.ofs_e = pofs;
      end
      next_s.ofs_wsel = ~s.ofs_wsel;
    end
    // Serial load shares the fall-through pin after master reset
    if (!clr_data && s.cfg.serial && !offset_load_n_i && !serial_en_n_i) begin
      {next_s.ofs_e, next_s.ofs_f} = {s.ofs_e[8:0], s.ofs_f,
                                      fall_through_mode_select_i};
    end
    if (ofs_rd) begin
      next_s.dout = {8'h00, s.ofs_rsel ? s.ofs_f : s.ofs_e};
      next_s.ofs_rsel = ~s.ofs_rsel;
    end

    // Preset offset from {load, sel1, sel0}
    unique case ({offset_load_n_i, default_offset_sel1_i,
                  default_offset_sel0_i})
      3'h0: dofs = `BMF_DOFS0;
      3'h1: dofs = `BMF_DOFS1;
      3'h2: dofs = `BMF_DOFS2;
      3'h3: dofs = `BMF_DOFS3;
      3'h4: dofs = `BMF_DOFS4;
      3'h5: dofs = `BMF_DOFS5;
      3'h6: dofs = `BMF_DOFS6;
      3'h7: dofs = `BMF_DOFS7;
    endcase

    // Partial reset keeps modes and offsets
    if (clr_data) begin
      next_s.wptr = 10'h000;
      next_s.rptr = 10'h000;
      next_s.count = 11'h000;
      next_s.dout = 18'h00000;
      next_s.ovalid = 1'b0;
      next_s.ofs_wsel = 1'b0;
      next_s.ofs_rsel = 1'b0;
    end
    // Configuration caught only while master reset stands
    if (s.mrs_act) begin
      next_s.cfg.fall_through_mode_select = fall_through_mode_select_i;
      next_s.cfg.narrow_wr = write_width_select_i;
      next_s.cfg.narrow_rd = read_width_select_i;
      next_s.cfg.little = byte_order_select_i;
      next_s.cfg.pfm_sync = flag_mode_select_i;
      next_s.cfg.serial = offset_load_n_i;
      next_s.cfg.par_int = parity_placement_select_i;
      next_s.cfg.rm_normal = retransmit_mode_select_i;
      next_s.ofs_e = dofs;
      next_s.ofs_f = dofs;
    end

    // Flags follow the next count so pins match the state they report
    if (next_s.cfg.fall_through_mode_select) begin
      next_s.ef_n = ~next_s.ovalid;
      next_s.ff_n = ~(`BMF_DEPTH - next_s.count >= in_bytes);
    end else begin
      next_s.ef_n = next_s.count >= out_bytes;
      next_s.ff_n = `BMF_DEPTH - next_s.count >= in_bytes;
    end
    next_s.hf_n = ~(next_s.count > `BMF_HALF);
    next_s.pae_n = ~(next_s.count < {1'b0, next_s.ofs_e});
    next_s.paf_n = ~(`BMF_DEPTH - next_s.count <= {1'b0, next_s.ofs_f});

    // Register reads answer one cycle later, zero otherwise
    next_s.rdata = 16'h0000;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `BMF_REG_STAT: next_s.rdata = {8'h00, s.cfg};
        `BMF_REG_COUNT: next_s.rdata = {5'h00, s.count};
        `BMF_REG_CTRL: next_s.rdata = 16'h0000;
        `BMF_REG_OFS: next_s.rdata = {s.ofs_f[7:0], s.ofs_e[7:0]};
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.mrs_act <= 1'b1;
      // Partial reset pin idles high; no false partial reset after reset
      s.prs_sync <= 3'h7;
      s.oe_n <= 1'b1;
      s.ef_n <= 1'b0;
      s.ff_n <= 1'b1;
      s.hf_n <= 1'b1;
      s.pae_n <= 1'b0;
      s.paf_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Storage is not reset; pointers guard against stale contents
  always_ff @(posedge clock_i) begin
    if (mem_we0) begin
      mem[s.wptr] <= mem_d0;
    end
    if (mem_we1) begin
      mem[wptr1] <= mem_d1;
    end
  end

  assign read_data_outputs_o = s.dout;
  assign read_data_oe_n_o = s.oe_n;
  assign empty_flag_n_o = s.ef_n;
  assign full_flag_n_o = s.ff_n;
  assign half_full_flag_n_o = s.hf_n;
  assign almost_empty_flag_n_o = s.pae_n;
  assign almost_full_flag_n_o = s.paf_n;
  assign reg_rdata_o = s.rdata;

  a_mrs_clears_ptr: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s.mrs_act |=> (s.wptr == 10'h000) && (s.rptr == 10'h000) &&
                  (s.dout == 18'h00000))
    else $error("master reset left pointers or output set");

  a_cfg_held_after: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !s.mrs_act |=> $stable(s.cfg))
    else $error("configuration changed outside master reset");

  a_prs_keeps_ofs: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s.prs_act && !s.mrs_act) |=> $stable(s.ofs_e) && $stable(s.ofs_f) &&
                                  (s.count == 11'h000))
    else $error("partial reset disturbed offsets or kept data");

  a_width_latch: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s.mrs_act |=> s.cfg.narrow_wr == $past(write_width_select_i))
    else $error("write width not caught from its strap");

  a_rd_width_latch: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s.mrs_act |=> s.cfg.narrow_rd == $past(read_width_select_i))
    else $error("read width not caught from its strap");

  a_order_latch: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s.mrs_act ##1 s.mrs_act |-> s.cfg.little == $past(byte_order_select_i))
    else $error("byte order not caught from its strap");

  a_half_full_pin: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !s.mrs_act ##1 !s.mrs_act |-> half_full_flag_n_o ==
                                  !(s.count > `BMF_HALF))
    else $error("half-full pin disagrees with count");

  a_empty_std: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!s.cfg.fall_through_mode_select && $stable(s.cfg)) |-> empty_flag_n_o ==
                                        (s.count >= out_bytes))
    else $error("empty pin disagrees with count");

  a_full_std: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!s.cfg.fall_through_mode_select && $stable(s.cfg)) |-> full_flag_n_o == (space >= in_bytes))
    else $error("full pin disagrees with free space");

  a_oe_follows: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    1'b1 |=> read_data_oe_n_o == $past(output_enable_n_i))
    else $error("output enable not followed in one cycle");

  a_load_no_store: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!clr_data && !offset_load_n_i && !write_en_n_i) |=> $stable(s.wptr))
    else $error("write reached storage while load was asserted");

endmodule // bmf_fifo

// [bmf_fifo_tb.sv]
// Self-checking bench for the bus-matching FIFO configuration block
`timescale 1ns/1ns
`include "bmf_params.svh"
module bmf_fifo_tb;
  logic clock_i, rst_n_i, mrs_n, prs_n, ofs_ld_n, ren_n, oe_n, req, re, we;
  logic wen_n, qoe_n, ef_n, ff_n, hf_n, pae_n, paf_n;
  logic sen_n, ftsi;
  logic [1:0] addr, sel;
  logic [15:0] wdata, rdata;
  logic [17:0] dat, q, wd, r, d0, d1;
  logic [9:0] p;
  logic [19:0] sv;
  bmf_pkg::bmf_cfg_t cfg, c;
  logic [8:0] bq[$];
  int bad_count, comparisons, n;

  bmf_writer wr_u (.req_i(req), .narrow_i(cfg.narrow_wr), .data_i(dat),
    .write_en_n_o(wen_n), .write_data_o(wd));
  bmf_fifo dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .master_reset_n_i(mrs_n), .partial_reset_n_i(prs_n),
    .byte_order_select_i(cfg.little), .fall_through_mode_select_i(ftsi),
    .default_offset_sel0_i(sel[0]), .default_offset_sel1_i(sel[1]),
    .parity_placement_select_i(cfg.par_int),
    .write_width_select_i(cfg.narrow_wr), .read_width_select_i(cfg.narrow_rd),
    .flag_mode_select_i(cfg.pfm_sync), .retransmit_mode_select_i(cfg.rm_normal),
    .write_en_n_i(wen_n), .serial_en_n_i(sen_n), .offset_load_n_i(ofs_ld_n),
    .write_data_inputs_i(wd), .read_en_n_i(ren_n), .output_enable_n_i(oe_n),
    .read_data_outputs_o(q), .read_data_oe_n_o(qoe_n), .empty_flag_n_o(ef_n),
    .full_flag_n_o(ff_n), .half_full_flag_n_o(hf_n),
    .almost_empty_flag_n_o(pae_n), .almost_full_flag_n_o(paf_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  function automatic logic [9:0] preset(input logic [2:0] i);
    return (10'h001 << (4'(i) + 4'h3)) - 10'h001;
  endfunction

  function automatic void push_word(input logic [17:0] d);
    if (cfg.narrow_wr || cfg.little) bq.push_back(d[8:0]);
    if (!cfg.narrow_wr) bq.push_back(d[17:9]);
    if (!cfg.narrow_wr && !cfg.little) bq.push_back(d[8:0]);
  endfunction

  function automatic logic [17:0] pop_unit();
    logic [8:0] b0;
    logic [8:0] b1;
    b0 = bq.pop_front();
    if (cfg.narrow_rd) return {9'h000, b0};
    b1 = bq.pop_front();
    return cfg.little ? {b1, b0} : {b0, b1};
  endfunction

  task automatic check_val(input logic [17:0] g, input logic [17:0] e,
                           input string what);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic check_flag(input logic g, input logic e, input string what);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, g, e);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a);
    @(posedge clock_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    re <= 1'b0;
    #1 r = {2'b00, rdata};
  endtask

  task automatic wr(input logic [17:0] d, input bit keep);
    @(posedge clock_i);
    req <= 1'b1;
    dat <= d;
    @(posedge clock_i);
    req <= 1'b0;
    if (keep) push_word(d);
    #1;
  endtask

  task automatic rd();
    @(posedge clock_i);
    ren_n <= 1'b0;
    @(posedge clock_i);
    ren_n <= 1'b1;
    #1;
  endtask

  task automatic master_reset(input bmf_pkg::bmf_cfg_t m, input logic [1:0] s);
    @(posedge clock_i);
    mrs_n <= 1'b0;
    cfg <= m;
    sel <= s;
    ofs_ld_n <= m.serial;
    ftsi <= m.fall_through_mode_select;
    repeat (5) @(posedge clock_i);
    mrs_n <= 1'b1;
    repeat (8) @(posedge clock_i);
    ofs_ld_n <= 1'b1;
    bq.delete();
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    complete_run();
  end

  initial begin
    {rst_n_i, mrs_n, req, re, we, sel, addr, wdata, dat, cfg, ftsi} = '0;
    {prs_n, ofs_ld_n, ren_n, oe_n, sen_n} = 5'h1f;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(32'h65a2));
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // Every preset index, other straps random, then a short data run
    for (int i = 0; i < 8; i++) begin
      c = bmf_pkg::bmf_cfg_t'(8'($urandom()));
      c.serial = i[2];
      master_reset(c, i[1:0]);
      p = preset(3'(i));
      check_val(q, 18'h00000, "output after master reset");
      check_flag(ef_n, c.fall_through_mode_select, "empty pin after reset");
      check_flag(ff_n, ~c.fall_through_mode_select, "full pin after reset");
      reg_rd(`BMF_REG_STAT);
      check_val(r, {10'h000, c}, "mode word");
      reg_rd(`BMF_REG_OFS);
      check_val(r, {2'b00, p[7:0], p[7:0]}, "preset offsets");
      d0 = 18'($urandom());
      d1 = 18'($urandom());
      wr(d0, 1'b1);
      wr(d1, 1'b1);
      n = 0;
      if (c.fall_through_mode_select) begin
        while (ef_n !== 1'b0 && n < 10) begin
          @(posedge clock_i);
          #1 n++;
        end
        check_val(q, pop_unit(), "fall-through word");
      end
      while (bq.size() >= (c.narrow_rd ? 1 : 2)) begin
        rd();
        check_val(q, pop_unit(), "read data");
      end
      $display("test modes index %0d done", i);
    end
    // Fill to full and one refused write
    master_reset(8'h1b, 2'h0);
    for (int k = 1; k <= 513; k++) begin
      wr(18'(k), k <= 512);
      n = (k > 512) ? 1024 : 2 * k;
      check_flag(hf_n, n <= 512, "half full");
      check_flag(ff_n, n < 1024, "full");
      check_flag(pae_n, n >= 7, "almost empty");
      check_flag(paf_n, 1024 - n > 7, "almost full");
      check_flag(ef_n, 1'b1, "not empty");
    end
    rd();
    check_val(q, pop_unit(), "first word after fill");
    @(posedge clock_i);
    prs_n <= 1'b0;
    repeat (5) @(posedge clock_i);
    prs_n <= 1'b1;
    repeat (8) @(posedge clock_i);
    #1 check_val(q, 18'h00000, "output after partial reset");
    check_flag(ef_n, 1'b0, "empty after partial reset");
    reg_rd(`BMF_REG_COUNT);
    check_val(r, 18'h00000, "count after partial reset");
    reg_rd(`BMF_REG_OFS);
    check_val(r, 18'h00707, "offsets kept");
    $display("test fill and partial reset done");
    // Soft partial reset, write to a read-only place
    wr(18'h2a5a5, 1'b1);
    reg_wr(`BMF_REG_CTRL, 16'h0001);
    reg_wr(`BMF_REG_STAT, 16'hffff);
    repeat (3) @(posedge clock_i);
    reg_rd(`BMF_REG_COUNT);
    check_val(r, 18'h00000, "count after soft reset");
    reg_rd(`BMF_REG_STAT);
    check_val(r, 18'h0001b, "mode word kept");
    reg_rd(`BMF_REG_CTRL);
    check_val(r, 18'h00000, "control reads zero");
    // Parallel offset load; parity lane D8 dropped when interspersed
    bq.delete();
    wr(18'h12345, 1'b1);
    @(posedge clock_i);
    ofs_ld_n <= 1'b0;
    wr(18'h001a5, 1'b0);
    wr(18'h0073c, 1'b0);
    rd();
    check_val(q, 18'h000a5, "empty offset readback");
    rd();
    check_val(q, 18'h0033c, "full offset readback");
    @(posedge clock_i);
    ofs_ld_n <= 1'b1;
    reg_rd(`BMF_REG_OFS);
    check_val(r, 18'h03ca5, "loaded offsets");
    reg_rd(`BMF_REG_COUNT);
    check_val(r, 18'h00002, "count untouched");
    rd();
    check_val(q, pop_unit(), "stored word after offsets");
    for (int v = 0; v < 2; v++) begin
      @(posedge clock_i);
      oe_n <= v[0];
      repeat (2) @(posedge clock_i);
      #1 check_flag(qoe_n, v[0], "output drive");
    end
    $display("test registers and offsets done");
    // Serial offset load shifts through the fall-through pin
    master_reset(8'h04, 2'h0);
    sv = 20'($urandom());
    @(posedge clock_i);
    ofs_ld_n <= 1'b0;
    sen_n <= 1'b0;
    for (int b = 19; b >= 0; b--) begin
      ftsi <= sv[b];
      @(posedge clock_i);
    end
    sen_n <= 1'b1;
    rd();
    check_val(q, {8'h00, sv[19:10]}, "serial empty offset");
    rd();
    check_val(q, {8'h00, sv[9:0]}, "serial full offset");
    @(posedge clock_i);
    ofs_ld_n <= 1'b1;
    $display("test serial offsets done");
    complete_run();
  end
endmodule // bmf_fifo_tb

// [bmf_params.svh]
// Constants for the bus-matching FIFO configuration block
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH

// Storage geometry, counted in 9-bit byte lanes
`define BMF_AW 10
`define BMF_CW 11
`define BMF_DEPTH 11'h400
`define BMF_HALF 11'h200
`define BMF_ONE_B 11'h001
`define BMF_TWO_B 11'h002
`define BMF_PTR_ONE 10'h001
`define BMF_PTR_TWO 10'h002
`define BMF_OFS_W 10

// Eight preset flag offsets, index {load, sel1, sel0}
`define BMF_DOFS0 10'h007
`define BMF_DOFS1 10'h00f
`define BMF_DOFS2 10'h01f
`define BMF_DOFS3 10'h03f
`define BMF_DOFS4 10'h07f
`define BMF_DOFS5 10'h0ff
`define BMF_DOFS6 10'h1ff
`define BMF_DOFS7 10'h3ff

// Register port map
`define BMF_REG_STAT 2'h0
`define BMF_REG_COUNT 2'h1
`define BMF_REG_CTRL 2'h2
`define BMF_REG_OFS 2'h3
`define BMF_CTRL_PRS 0

`endif

// [bmf_pkg.sv]
// Types for the bus-matching FIFO configuration block
package bmf_pkg;

  // Mode choices caught during master reset
  typedef struct packed {
    logic fall_through_mode_select;
    logic narrow_wr;
    logic narrow_rd;
    logic little;
    logic pfm_sync;
    logic serial;
    logic par_int;
    logic rm_normal;
  } bmf_cfg_t;

  // State of the block, apart from the storage array
  typedef struct packed {
    logic [2:0] mrs_sync;
    logic [2:0] prs_sync;
    logic mrs_act;
    logic prs_act;
    logic sw_prs;
    bmf_cfg_t cfg;
    logic [9:0] wptr;
    logic [9:0] rptr;
    logic [10:0] count;
    logic [17:0] dout;
    logic ovalid;
    logic oe_n;
    logic ef_n;
    logic ff_n;
    logic hf_n;
    logic pae_n;
    logic paf_n;
    logic [9:0] ofs_e;
    logic [9:0] ofs_f;
    logic ofs_wsel;
    logic ofs_rsel;
    logic [15:0] rdata;
  } bmf_state_t;

endpackage

// [bmf_writer.sv]
// Far-side writer model for the bus-matching FIFO
`timescale 1ns/1ns
module bmf_writer (
  // Requests from the bench
  input wire logic req_i,
  input wire logic narrow_i,
  input wire logic [17:0] data_i,
  // Write port pins
  output logic write_en_n_o,
  output logic [17:0] write_data_o
);
  logic [17:0] word;
  // Idle bus shows inverted data, never a stale copy
  assign word = req_i ? data_i : ~data_i;
  assign write_en_n_o = ~req_i;
  assign write_data_o = narrow_i ? {9'h000, word[8:0]} : word;
endmodule // bmf_writer
